// ### src/bmq_block_memory_queue.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - two independently configured ports; single-port, dual-port and read-only use.
// - each port selects widths 40,20,18,16,10,9,8,5,4,2,1 bits.
// - reads and writes happen on the port clock edge, inputs sampled.
// - optional output register adds exactly one cycle of read latency.
// - output register reset value is separate from its power-up value.
// - write-through mode shows the written data on read output.
// - hold mode keeps read output unchanged during a write.
// - queue mode has pointer and flag logic, 512x40 down to 16kx1.
// - common-clock setting gives faster synchronous flags and pointers.
// - 40-bit simple dual-port mode may protect 32 bits, SEC-DED.
// - without error correction all 40 bits are user storage.
// - contents preloaded at configuration, otherwise all zero.
// - reset keeps the array, output register takes its reset value.
// - read output start value may be set at configuration.
module bmq_block_memory_queue
    import bmq_pkg::*;
#(
    parameter logic [DW-1:0]       OUT_INIT_A = '0,
    parameter logic [DW-1:0]       OUT_INIT_B = '0,
    parameter logic [DW-1:0]       OUT_RST_A  = '0,
    parameter logic [DW-1:0]       OUT_RST_B  = '0,
    parameter logic [RAM_BITS-1:0] MEM_INIT   = '0
) (
    // clock and reset
    input  wire logic            clk_in,
    input  wire logic            nrst_in,
    // register port
    input  wire logic [RA_W-1:0] reg_addr_in,
    input  wire logic [RD_W-1:0] reg_wdata_in,
    input  wire logic            reg_wr_in,
    input  wire logic            reg_rd_in,
    output logic      [RD_W-1:0] reg_rdata_out,
    // port a
    input  wire bmq_port_req_t   porta_in,
    input  wire logic            porta_rst_in,
    output logic      [DW-1:0]   porta_dout_out,
    // port b
    input  wire bmq_port_req_t   portb_in,
    input  wire logic            portb_rst_in,
    output logic      [DW-1:0]   portb_dout_out,
    output logic                 portb_sec_out,
    output logic                 portb_ded_out,
    // queue flags and interrupt
    output logic                 fifo_full_out,
    output logic                 fifo_empty_out,
    output logic                 irq_out
);

    localparam bmq_state_t ST_RST = '{
        mem:   MEM_INIT,
        ctrl:  CTRL_RST,
        stat:  '0,
        ien:   '0,
        rdata: '0,
        lat_a: OUT_INIT_A,
        out_a: OUT_INIT_A,
        lat_b: OUT_INIT_B,
        out_b: OUT_INIT_B,
        sec_b: 1'b0,
        ded_b: 1'b0,
        wp:    '0,
        rp:    '0,
        wp_d1: '0,
        wp_d2: '0,
        rp_d1: '0,
        rp_d2: '0
    };

    ////////////////////////////////////////////////////////////////////////
    // slice helpers

    function automatic logic [DW-1:0] rd_slice(
        input logic [RAM_BITS-1:0] m,
        input logic [PW-1:0]       b,
        input logic [5:0]          w
    );
        logic [DW-1:0] r;
        int            i;
        r = '0;
        for (i = 0; i < DW; i++) begin
            if (i < int'(w) && int'(b) + i < RAM_BITS) begin
                r[i] = m[int'(b) + i];
            end
        end
        return r;
    endfunction : rd_slice

    function automatic logic [RAM_BITS-1:0] wr_slice(
        input logic [RAM_BITS-1:0] m,
        input logic [PW-1:0]       b,
        input logic [5:0]          w,
        input logic [DW-1:0]       d
    );
        logic [RAM_BITS-1:0] r;
        int                  i;
        r = m;
        for (i = 0; i < DW; i++) begin
            if (i < int'(w) && int'(b) + i < RAM_BITS) begin
                r[int'(b) + i] = d[i];
            end
        end
        return r;
    endfunction : wr_slice

    function automatic logic [DW-1:0] trim(
        input logic [DW-1:0] d,
        input logic [5:0]    w
    );
        logic [DW-1:0] r;
        int            i;
        r = '0;
        for (i = 0; i < DW; i++) begin
            if (i < int'(w)) begin
                r[i] = d[i];
            end
        end
        return r;
    endfunction : trim

    ////////////////////////////////////////////////////////////////////////
    // decode of configuration and port requests

    bmq_state_t     s_reg;
    bmq_state_t     s_next;
    logic [5:0]     wid_a;
    logic [5:0]     wid_b;
    logic [PW-1:0]  depth;
    logic [PW-1:0]  pmask;
    logic           fifo;
    logic           ecc_on;
    logic [PW-1:0]  wp_seen;
    logic [PW-1:0]  rp_seen;
    logic [PW-1:0]  count;
    logic           full;
    logic           empty;
    logic [AW-1:0]  adr_a;
    logic [AW-1:0]  adr_b;
    logic [PW-1:0]  bit_a;
    logic [PW-1:0]  bit_b;
    logic           wr_a;
    logic           rd_a;
    logic           wr_b;
    logic           rd_b;
    logic [DW-1:0]  wdat_a;
    logic [DW-1:0]  raw_b;
    bmq_dec_t       dec_b;
    logic [NEV-1:0] ev;
    bmq_level_t     lvl;

    assign fifo  = s_reg.ctrl.mode == BMQ_FIFO;
    assign wid_a = bmq_width_of(s_reg.ctrl.wcode_a);
    assign wid_b = fifo ? wid_a : bmq_width_of(s_reg.ctrl.wcode_b);
    assign depth = bmq_depth_of(s_reg.ctrl.wcode_a);
    assign pmask = PW'((32'(depth) << 1) - 32'd1);

    // common clock: live pointers; otherwise flags see delayed copies
    assign wp_seen = s_reg.ctrl.sync ? s_reg.wp : s_reg.wp_d2;
    assign rp_seen = s_reg.ctrl.sync ? s_reg.rp : s_reg.rp_d2;
    assign count   = (s_reg.wp - s_reg.rp) & pmask;
    assign full    = ((s_reg.wp - rp_seen) & pmask) == depth;
    assign empty   = wp_seen == s_reg.rp;

    assign adr_a = fifo ? AW'(s_reg.wp & (depth - 15'h1)) : porta_in.addr;
    assign adr_b = fifo ? AW'(s_reg.rp & (depth - 15'h1)) : portb_in.addr;
    assign bit_a = PW'(32'(adr_a) * 32'(wid_a));
    assign bit_b = PW'(32'(adr_b) * 32'(wid_b));

    // ecc only in 40-bit simple dual-port
    assign ecc_on = s_reg.ctrl.ecc_en && s_reg.ctrl.mode == BMQ_SDP
                    && s_reg.ctrl.wcode_a == WCODE_40;

    always_comb begin
        wr_a = 1'b0;
        rd_a = 1'b0;
        wr_b = 1'b0;
        rd_b = 1'b0;
        case (s_reg.ctrl.mode)
            BMQ_RAM: begin
                wr_a = porta_in.en && porta_in.we;
                rd_a = porta_in.en && !porta_in.we;
                wr_b = portb_in.en && portb_in.we;
                rd_b = portb_in.en && !portb_in.we;
            end
            BMQ_SDP: begin
                wr_a = porta_in.en && porta_in.we;
                rd_b = portb_in.en;
            end
            BMQ_ROM: begin
                rd_a = porta_in.en;
                rd_b = portb_in.en;
            end
            default: begin
                wr_a = porta_in.en && porta_in.we && !full;
                rd_b = portb_in.en && !empty;
            end
        endcase
    end

    assign wdat_a = ecc_on ? bmq_ecc_enc(porta_in.din[ED-1:0])
                           : porta_in.din;
    assign raw_b  = rd_slice(s_reg.mem, bit_b, wid_b);
    assign dec_b  = bmq_ecc_dec(raw_b);

    always_comb begin
        ev         = '0;
        ev[EV_OVF] = fifo && porta_in.en && porta_in.we && full;
        ev[EV_UNF] = fifo && portb_in.en && empty;
        ev[EV_SEC] = rd_b && ecc_on && dec_b.sec;
        ev[EV_DED] = rd_b && ecc_on && dec_b.ded;
    end

    always_comb begin
        lvl       = '0;
        lvl.full  = full;
        lvl.empty = empty;
        lvl.count = count;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_next = s_reg;

        // array: b writes after a, so b wins a same-cell collision
        if (wr_a) begin
            s_next.mem = wr_slice(s_next.mem, bit_a, wid_a, wdat_a);
        end
        if (wr_b) begin
            s_next.mem = wr_slice(s_next.mem, bit_b, wid_b,
                                  portb_in.din);
        end

        // port a read latch
        if (wr_a) begin
            if (s_reg.ctrl.wmode_a == BMQ_WR_FIRST) begin
                s_next.lat_a = trim(porta_in.din, wid_a);
            end
        end else if (rd_a) begin
            s_next.lat_a = rd_slice(s_reg.mem, bit_a, wid_a);
        end

        // port b read latch
        s_next.sec_b = 1'b0;
        s_next.ded_b = 1'b0;
        if (wr_b) begin
            if (s_reg.ctrl.wmode_b == BMQ_WR_FIRST) begin
                s_next.lat_b = trim(portb_in.din, wid_b);
            end
        end else if (rd_b) begin
            s_next.lat_b = ecc_on ? DW'(dec_b.data) : raw_b;
            s_next.sec_b = ev[EV_SEC];
            s_next.ded_b = ev[EV_DED];
        end

        // output registers: one extra stage, own reset value
        if (porta_rst_in) begin
            s_next.out_a = OUT_RST_A;
        end else begin
            s_next.out_a = s_reg.lat_a;
        end
        if (portb_rst_in) begin
            s_next.out_b = OUT_RST_B;
        end else begin
            s_next.out_b = s_reg.lat_b;
        end

        // queue pointers
        if (fifo && wr_a) begin
            s_next.wp = (s_reg.wp + 15'h1) & pmask;
        end
        if (fifo && rd_b) begin
            s_next.rp = (s_reg.rp + 15'h1) & pmask;
        end
        s_next.wp_d1 = s_reg.wp;
        s_next.wp_d2 = s_reg.wp_d1;
        s_next.rp_d1 = s_reg.rp;
        s_next.rp_d2 = s_reg.rp_d1;

        // events: a new event beats a clear in the same cycle
        s_next.stat = s_reg.stat;
        if (reg_wr_in && reg_addr_in == OFS_CLR) begin
            s_next.stat = s_reg.stat & ~reg_wdata_in[NEV-1:0];
        end
        s_next.stat = s_next.stat | ev;

        // register writes
        if (reg_wr_in) begin
            if (reg_addr_in == OFS_CTRL) begin
                s_next.ctrl  = bmq_ctrl_t'(reg_wdata_in[CTRL_W-1:0]);
                // new geometry empties the queue
                s_next.wp    = '0;
                s_next.rp    = '0;
                s_next.wp_d1 = '0;
                s_next.wp_d2 = '0;
                s_next.rp_d1 = '0;
                s_next.rp_d2 = '0;
            end else if (reg_addr_in == OFS_IEN) begin
                s_next.ien = reg_wdata_in[NEV-1:0];
            end
        end

        // register reads, answered next cycle
        s_next.rdata = '0;
        if (reg_rd_in) begin
            if (reg_addr_in == OFS_CTRL) begin
                s_next.rdata = RD_W'(s_reg.ctrl);
            end else if (reg_addr_in == OFS_STAT) begin
                s_next.rdata = RD_W'(s_reg.stat);
            end else if (reg_addr_in == OFS_IEN) begin
                s_next.rdata = RD_W'(s_reg.ien);
            end else if (reg_addr_in == OFS_LVL) begin
                s_next.rdata = lvl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register: reset is the configuration load

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= ST_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign porta_dout_out = s_reg.ctrl.oreg_a ? s_reg.out_a
                                              : s_reg.lat_a;
    assign portb_dout_out = s_reg.ctrl.oreg_b ? s_reg.out_b
                                              : s_reg.lat_b;
    assign portb_sec_out  = s_reg.sec_b;
    assign portb_ded_out  = s_reg.ded_b;
    assign fifo_full_out  = full;
    assign fifo_empty_out = empty;
    assign reg_rdata_out  = s_reg.rdata;
    assign irq_out        = |(s_reg.stat & s_reg.ien);

endmodule : bmq_block_memory_queue

// ### src/bmq_pkg.sv
package bmq_pkg;

    localparam int RAM_BITS = 20480;
    localparam int DW       = 40;
    localparam int AW       = 14;
    localparam int PW       = 15;
    localparam int ED       = 32;
    localparam int HP       = 6;
    localparam int RA_W     = 8;
    localparam int RD_W     = 32;
    localparam int NEV      = 4;

    localparam logic [RA_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [RA_W-1:0] OFS_STAT = 8'h04;
    localparam logic [RA_W-1:0] OFS_CLR  = 8'h08;
    localparam logic [RA_W-1:0] OFS_IEN  = 8'h0c;
    localparam logic [RA_W-1:0] OFS_LVL  = 8'h10;

    localparam int EV_OVF = 0;
    localparam int EV_UNF = 1;
    localparam int EV_SEC = 2;
    localparam int EV_DED = 3;

    localparam logic [3:0] WCODE_40 = 4'h0;

    typedef enum logic [1:0] {
        BMQ_RAM  = 2'b00,
        BMQ_SDP  = 2'b01,
        BMQ_ROM  = 2'b10,
        BMQ_FIFO = 2'b11
    } bmq_mode_t;

    typedef enum logic {
        BMQ_WR_FIRST  = 1'b0,
        BMQ_NO_CHANGE = 1'b1
    } bmq_wmode_t;

    typedef struct packed {
        logic       sync;
        logic       ecc_en;
        logic       oreg_b;
        logic       oreg_a;
        bmq_wmode_t wmode_b;
        bmq_wmode_t wmode_a;
        logic [3:0] wcode_b;
        logic [3:0] wcode_a;
        bmq_mode_t  mode;
    } bmq_ctrl_t;

    localparam int CTRL_W = $bits(bmq_ctrl_t);
    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h8044;

    typedef struct packed {
        logic          en;
        logic          we;
        logic [AW-1:0] addr;
        logic [DW-1:0] din;
    } bmq_port_req_t;

    typedef struct packed {
        logic [RD_W-PW-3:0] pad;
        logic               full;
        logic               empty;
        logic [PW-1:0]      count;
    } bmq_level_t;

    typedef struct packed {
        logic          ded;
        logic          sec;
        logic [ED-1:0] data;
    } bmq_dec_t;

    typedef struct packed {
        logic [RAM_BITS-1:0] mem;
        bmq_ctrl_t           ctrl;
        logic [NEV-1:0]      stat;
        logic [NEV-1:0]      ien;
        logic [RD_W-1:0]     rdata;
        logic [DW-1:0]       lat_a;
        logic [DW-1:0]       out_a;
        logic [DW-1:0]       lat_b;
        logic [DW-1:0]       out_b;
        logic                sec_b;
        logic                ded_b;
        logic [PW-1:0]       wp;
        logic [PW-1:0]       rp;
        logic [PW-1:0]       wp_d1;
        logic [PW-1:0]       wp_d2;
        logic [PW-1:0]       rp_d1;
        logic [PW-1:0]       rp_d2;
    } bmq_state_t;

    function automatic logic [5:0] bmq_width_of(input logic [3:0] c);
        case (c)
            4'h0:    return 6'h28;
            4'h1:    return 6'h14;
            4'h2:    return 6'h12;
            4'h3:    return 6'h10;
            4'h4:    return 6'h0a;
            4'h5:    return 6'h09;
            4'h6:    return 6'h08;
            4'h7:    return 6'h05;
            4'h8:    return 6'h04;
            4'h9:    return 6'h02;
            default: return 6'h01;
        endcase
    endfunction : bmq_width_of

    function automatic logic [PW-1:0] bmq_depth_of(input logic [3:0] c);
        case (c)
            4'h0:                return 15'h0200;
            4'h1, 4'h2, 4'h3:    return 15'h0400;
            4'h4, 4'h5, 4'h6:    return 15'h0800;
            4'h7, 4'h8:          return 15'h1000;
            4'h9:                return 15'h2000;
            default:             return 15'h4000;
        endcase
    endfunction : bmq_depth_of

    // hamming over positions 1..39, overall parity in bit 0
    function automatic logic [DW-1:0] bmq_ecc_enc(input logic [ED-1:0] d);
        logic [DW-1:0] c;
        int            j;
        int            k;
        int            p;
        c = '0;
        k = 0;
        for (j = 1; j < DW; j++) begin
            if ((j & (j - 1)) != 0 && k < ED) begin
                c[j] = d[k];
                k++;
            end
        end
        for (p = 0; p < HP; p++) begin
            for (j = 1; j < DW; j++) begin
                if (((j >> p) & 1) == 1 && j != (1 << p)) begin
                    c[1 << p] ^= c[j];
                end
            end
        end
        c[0] = ^c[DW-1:1];
        return c;
    endfunction : bmq_ecc_enc

    function automatic bmq_dec_t bmq_ecc_dec(input logic [DW-1:0] cw);
        bmq_dec_t      r;
        logic [DW-1:0] c;
        logic [5:0]    syn;
        logic          par;
        int            j;
        int            k;
        c   = cw;
        syn = '0;
        r   = '0;
        for (j = 1; j < DW; j++) begin
            if (c[j]) begin
                syn ^= 6'(j);
            end
        end
        par = ^c;
        if (par && int'(syn) < DW) begin
            c[syn] = ~c[syn];
        end
        r.sec = par && int'(syn) < DW;
        r.ded = (!par && syn != '0) || (par && int'(syn) >= DW);
        k = 0;
        for (j = 1; j < DW; j++) begin
            if ((j & (j - 1)) != 0 && k < ED) begin
                r.data[k] = c[j];
                k++;
            end
        end
        return r;
    endfunction : bmq_ecc_dec

endpackage : bmq_pkg

// ### verification/bmq_block_memory_queue_sva.sv
`timescale 1ns/1ps
module bmq_chk
    import bmq_pkg::*;
#(
    parameter logic [DW-1:0] OUT_RST_A = '0
) (
    // clock, reset and register port
    input logic            clk_in,
    input logic            nrst_in,
    input logic [RA_W-1:0] reg_addr_in,
    input logic [RD_W-1:0] reg_wdata_in,
    input logic            reg_wr_in,
    input logic            reg_rd_in,
    input logic [RD_W-1:0] reg_rdata_out,
    // memory ports and flags
    input bmq_port_req_t   porta_in,
    input logic            porta_rst_in,
    input logic [DW-1:0]   porta_dout_out,
    input logic            portb_sec_out,
    input logic            portb_ded_out,
    input logic            fifo_full_out,
    input logic            fifo_empty_out,
    input logic            irq_out
);
    bmq_ctrl_t      ctl_reg;
    logic [NEV-1:0] ien_reg;
    logic           ram_a;
    logic           que_a;
    logic           wr_a;
    logic           wf_a;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctl_reg <= bmq_ctrl_t'(CTRL_RST);
            ien_reg <= '0;
        end else if (reg_wr_in && reg_addr_in == OFS_CTRL) begin
            ctl_reg <= bmq_ctrl_t'(reg_wdata_in[CTRL_W-1:0]);
        end else if (reg_wr_in && reg_addr_in == OFS_IEN) begin
            ien_reg <= reg_wdata_in[NEV-1:0];
        end
    end
    assign wr_a  = porta_in.en && porta_in.we && !reg_wr_in;
    assign ram_a = ctl_reg.mode == BMQ_RAM && ctl_reg.wcode_a == 4'h1;
    assign que_a = ctl_reg.mode == BMQ_FIFO && fifo_empty_out && wr_a;
    assign wf_a  = ram_a && wr_a && ctl_reg.wmode_a == BMQ_WR_FIRST;
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    chk_rdata_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == '0)
        else $error("read data outside a read");
    chk_flag_excl: assert property (
        !(fifo_full_out && fifo_empty_out))
        else $error("full and empty together");
    chk_ecc_excl: assert property (
        !(portb_sec_out && portb_ded_out))
        else $error("corrected and double together");
    chk_wf_show: assert property (
        wf_a && !ctl_reg.oreg_a
        |=> porta_dout_out == {20'h0, $past(porta_in.din[19:0])})
        else $error("write data not shown");
    chk_nc_hold: assert property (
        ram_a && wr_a && ctl_reg.wmode_a == BMQ_NO_CHANGE && !ctl_reg.oreg_a
        |=> $stable(porta_dout_out))
        else $error("read output moved on write");
    chk_oreg_lag: assert property (
        wf_a && ctl_reg.oreg_a ##1 !porta_rst_in && !reg_wr_in
        |=> porta_dout_out == {20'h0, $past(porta_in.din[19:0], 2)})
        else $error("wrong latency");
    chk_orst_val: assert property (
        ctl_reg.oreg_a && porta_rst_in && !reg_wr_in
        |=> porta_dout_out == OUT_RST_A)
        else $error("wrong reset value");
    chk_q_sync: assert property (
        que_a && ctl_reg.sync |=> !fifo_empty_out)
        else $error("empty late in common clock");
    chk_q_async: assert property (
        que_a && !ctl_reg.sync |=> fifo_empty_out [*2] ##1 !fifo_empty_out)
        else $error("split clock empty timing");
    chk_irq_en: assert property (
        irq_out |-> ien_reg != '0)
        else $error("irq with none enabled");
endmodule : bmq_chk

// ### verification/bmq_block_memory_queue_tb.sv
`timescale 1ns/1ps
module bmq_block_memory_queue_tb
    import bmq_pkg::*;
;
    localparam logic [DW-1:0] INIT_A = 40'h12_3456_789a;
    localparam logic [DW-1:0] RST_A  = 40'h5a_5a00_a5a5;
    logic            clk_in, nrst_in, reg_wr, reg_rd, rst_a, rst_b;
    logic            sec, ded, full, empty, irq;
    logic [RA_W-1:0] reg_addr;
    logic [RD_W-1:0] reg_wdata, reg_rdata;
    bmq_port_req_t   pa, pb;
    logic [DW-1:0]   dout_a, dout_b;
    int              miscompares, compares;

    always #5 clk_in = ~clk_in;
    bmq_fabric_model fab (.clk_in(clk_in), .porta_out(pa), .portb_out(pb));
    bmq_block_memory_queue #(
        .OUT_INIT_A (INIT_A),
        .OUT_RST_A  (RST_A),
        .MEM_INIT   (RAM_BITS'(20'h12345))
    ) dut (
        .clk_in (clk_in), .nrst_in (nrst_in),
        .reg_addr_in (reg_addr), .reg_wdata_in (reg_wdata),
        .reg_wr_in (reg_wr), .reg_rd_in (reg_rd), .reg_rdata_out (reg_rdata),
        .porta_in (pa), .porta_rst_in (rst_a), .porta_dout_out (dout_a),
        .portb_in (pb), .portb_rst_in (rst_b), .portb_dout_out (dout_b),
        .portb_sec_out (sec), .portb_ded_out (ded),
        .fifo_full_out (full), .fifo_empty_out (empty), .irq_out (irq)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [DW-1:0] seen,
                         input logic [DW-1:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic reg_write(input logic [RA_W-1:0] a,
                             input logic [RD_W-1:0] d);
        @(posedge clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_in);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input string name, input logic [RA_W-1:0] a,
                             input logic [RD_W-1:0] e);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_in);
        reg_rd   <= 1'b0;
        #1;
        check(name, DW'(reg_rdata), DW'(e));
    endtask : reg_check
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        #1;
        check("init_a", dout_a, INIT_A);
        check("flags", DW'({full, empty}), 40'h1);
        reg_check("ctrl", OFS_CTRL, 32'h8044);
        reg_check("level", OFS_LVL, 32'h8000);
        reg_check("unmapped", 8'h20, '0);
        fab.acc(1'b0, 1'b0, '0, '0);
        #1;
        check("preload", dout_a, 40'h1_2345);
    endtask : t_reset

    task automatic t_ram;
        reg_write(OFS_CTRL, 32'h8244);
        fab.acc(1'b0, 1'b1, 14'h5, 40'hff_fffa_bcde);
        #1;
        check("wf_a", dout_a, 40'ha_bcde);
        fab.acc(1'b1, 1'b0, 14'h32, '0);
        #1;
        check("narrow_b", dout_b, 40'h2);
        fab.acc(1'b1, 1'b1, 14'h33, 40'h1);
        fab.acc(1'b0, 1'b0, 14'h5, '0);
        #1;
        check("mixed_a", dout_a, 40'ha_bcd6);
    endtask : t_ram

    task automatic t_mode;
        reg_write(OFS_CTRL, 32'h8444);
        fab.acc(1'b0, 1'b1, 14'h6, 40'h5_5555);
        #1;
        check("hold", dout_a, 40'ha_bcd6);
        reg_write(OFS_CTRL, 32'h9044);
        fab.acc(1'b0, 1'b1, 14'h6, 40'h1_2345);
        @(posedge clk_in);
        #1;
        check("oreg", dout_a, 40'h1_2345);
        @(posedge clk_in);
        rst_a <= 1'b1;
        @(posedge clk_in);
        rst_a <= 1'b0;
        #1;
        check("orst", dout_a, RST_A);
        fab.acc(1'b0, 1'b0, 14'h6, '0);
        @(posedge clk_in);
        #1;
        check("keep", dout_a, 40'h1_2345);
    endtask : t_mode

    task automatic t_fifo;
        int i;
        reg_write(OFS_CTRL, 32'h8003);
        reg_write(OFS_IEN, 32'h3);
        for (i = 0; i < 600 && full !== 1'b1; i++) begin
            fab.acc(1'b0, 1'b1, '0, DW'(i));
            #1;
        end
        check("depth", DW'(i), 40'h200);
        if (i == 600) begin
            report_and_stop;
        end
        reg_check("lvl_full", OFS_LVL, 32'h1_0200);
        fab.acc(1'b0, 1'b1, '0, 40'hffff);
        reg_check("ovf", OFS_STAT, 32'h1);
        check("irq_ovf", DW'(irq), 40'h1);
        reg_write(OFS_CLR, 32'hf);
        #1;
        check("irq_clr", DW'(irq), '0);
        for (i = 0; i < 512; i++) begin
            fab.acc(1'b1, 1'b0, '0, '0);
            #1;
            check("drain", dout_b, DW'(i));
        end
        check("empty", DW'(empty), 40'h1);
        fab.acc(1'b1, 1'b0, '0, '0);
        #1;
        check("unf_dout", dout_b, 40'h1ff);
        reg_check("unf", OFS_STAT, 32'h2);
        check("irq_unf", DW'(irq), 40'h1);
        reg_write(OFS_IEN, '0);
        #1;
        check("irq_mask", DW'(irq), '0);
        reg_write(OFS_CLR, 32'hf);
    endtask : t_fifo

    task automatic t_async;
        reg_write(OFS_CTRL, 32'h3);
        repeat (3) @(posedge clk_in);
        fab.acc(1'b0, 1'b1, '0, 40'h3c);
        #1;
        check("empty_c1", DW'(empty), 40'h1);
        repeat (2) @(posedge clk_in);
        #1;
        check("empty_c3", DW'(empty), '0);
        fab.acc(1'b1, 1'b0, '0, '0);
        #1;
        check("async_rd", dout_b, 40'h3c);
    endtask : t_async

    task automatic t_ecc;
        logic [DW-1:0] cw;
        logic [DW-1:0] flip [3];
        int            i;
        flip = '{40'h0, 40'h1_0000, 40'h3};
        reg_write(OFS_CTRL, 32'h8001);
        fab.acc(1'b0, 1'b1, 14'h3, 40'ha5_0f0f_f0f0);
        fab.acc(1'b1, 1'b0, 14'h3, '0);
        #1;
        check("raw40", dout_b, 40'ha5_0f0f_f0f0);
        reg_write(OFS_CTRL, 32'hc001);
        fab.acc(1'b0, 1'b1, 14'h4, 40'hff_dead_beef);
        reg_write(OFS_CTRL, 32'h8001);
        fab.acc(1'b1, 1'b0, 14'h4, '0);
        #1;
        cw = dout_b;
        for (i = 0; i < 3; i++) begin
            reg_write(OFS_CTRL, 32'h8001);
            fab.acc(1'b0, 1'b1, 14'h4, cw ^ flip[i]);
            reg_write(OFS_CTRL, 32'hc001);
            fab.acc(1'b1, 1'b0, 14'h4, '0);
            #1;
            if (i < 2) begin
                check("ecc_data", dout_b, 40'hdead_beef);
            end
            check("ecc_flags", DW'({ded, sec}), DW'(i));
        end
        reg_check("ecc_stat", OFS_STAT, 32'hc);
    endtask : t_ecc

    initial begin
        clk_in = 1'b0;
        nrst_in = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rst_a = 1'b0;
        rst_b = 1'b0;
        miscompares = 0;
        compares = 0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_reset;
        t_ram;
        t_mode;
        t_fifo;
        t_async;
        t_ecc;
        report_and_stop;
    end
endmodule : bmq_block_memory_queue_tb

bind bmq_block_memory_queue bmq_chk #(.OUT_RST_A(OUT_RST_A)) chk (.*);

// ### verification/bmq_fabric_model.sv
`timescale 1ns/1ps
module bmq_fabric_model
    import bmq_pkg::*;
(
    // clock
    input  wire logic    clk_in,
    // requests to both ports
    output bmq_port_req_t porta_out,
    output bmq_port_req_t portb_out
);
    initial begin
        porta_out = '0;
        portb_out = '0;
    end
    // one request for one edge; released lines show inverted values
    // 40-bit words only in simple dual-port or queue use
    // the two ports may differ in total bits; t_ram pairs 1kx20 (20480 bits) on port a with 8kx2 (16384 bits) on port b
    // never one cell from both ports in one cycle
    task automatic acc(input logic b, input logic we,
                       input logic [AW-1:0] a, input logic [DW-1:0] d);
        bmq_port_req_t r;
        bmq_port_req_t rel;
        r   = '{en: 1'b1, we: we, addr: a, din: d};
        rel = '{en: 1'b0, we: ~we, addr: ~a, din: ~d};
        @(posedge clk_in);
        porta_out <= b ? porta_out : r;
        portb_out <= b ? r : portb_out;
        @(posedge clk_in);
        porta_out <= b ? porta_out : rel;
        portb_out <= b ? rel : portb_out;
    endtask : acc
endmodule : bmq_fabric_model
